// *** test/host_model.sv ***
/*
 * Host model: one-cycle register accesses from the bus side.
 * Assumes the shared clock and a caller that waits for reset release.
 */
`default_nettype none
module host_model import regulator_mode_pkg::*; (
    input  wire logic        mclk_i,
    output var  reg_access_t a_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial a_o = '0;
    // One idle edge after each strobe keeps back-to-back calls apart
    task automatic x(input logic w, input logic [7:0] ad, input logic [7:0] d);
        @(posedge mclk_i) a_o <= {w, !w, ad, d};
        @(posedge mclk_i) a_o <= '0;
    endtask
endmodule
`default_nettype wire

// *** test/regulator_mode_enable_regs_tb.sv ***
/*
 * Bench: host model drives accesses, a watcher checks reads and control levels.
 * Assumes pins move randomly every cycle and only the host model touches the bus.
 */
`default_nettype none
module regulator_mode_enable_regs_tb import regulator_mode_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, en = 1'b0, sel = 1'b0, st = 1'b0, rq = 1'b0;
    logic [2:0] pp = 3'b000;
    logic [1:0] up = 2'b00;
    logic [7:0] mdl = 8'h18, mp = 8'h18;
    // Seed 52144
    logic [31:0] rng = 32'h0000cbb0;
    logic [7:0] q[$], v, rd;
    int mismatches = 0, checks_done = 0;
    reg_access_t a;
    control_out_t k;
    always #2 clk = ~clk;
    host_model h (.mclk_i(clk), .a_o(a));
    regulator_mode_enable_regs dut (.mclk_i(clk), .nrst_i(nrst), .access_i(a), .enable_pin_i(en),
        .voltage_select_pin_i(sel), .startup_i(st), .rdata_o(rd), .ctl_o(k));
    function automatic logic [31:0] xs(logic [31:0] y);
        y ^= y << 13;
        y ^= y >> 17;
        return y ^ (y << 5);
    endfunction
    // Expected control levels from a stored byte and pins {enable, select, start-up}
    function automatic control_out_t want(input logic [7:0] b, input logic [2:0] p);
        control_out_t c;
        c.tone_reduction              = b[5];
        c.forced_continuous_operation = b[1] | (b[2] & p[1]);
        c.ramp_active                 = b[4] | p[0] | c.forced_continuous_operation;
        c.converter_run               = b[0] & p[2];
        c.discharge_connect           = b[3] & ~c.converter_run;
        c.second_target_voltage       = p[1];
        return c;
    endfunction
    task automatic chk(input logic [7:0] g, w);
        checks_done++;
        if (g !== w) begin
            mismatches++;
            $display("wrong value %0t %h %h", $time, g, w);
        end
    endtask
    task automatic chk_ctl(input control_out_t g, w);
        checks_done++;
        if (g !== w) begin
            mismatches++;
            $display("wrong value %0t %h %h", $time, g, w);
        end
    endtask
    task automatic r(input logic [7:0] ad, w);
        q.push_back(w);
        h.x(0, ad, 8'h00);
    endtask
    task wrap_up;
        if (q.size() != 0) mismatches++;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Pins move every cycle so each pin-driven output sees both levels
    always @(posedge clk) begin
        rng <= xs(rng);
        {en, sel, st} <= rng[2:0];
        rq <= a.rd;
        pp <= {en, sel, st};
        up <= {up[0], nrst};
        mp <= mdl;
        // Own copy of the enable byte, built from what the host wrote
        if (!nrst) mdl <= 8'h18;
        else if (a.wr && a.addr == 8'h06) mdl <= a.wdata & 8'h3f;
        else if (a.wr && a.addr == 8'h09 && a.wdata == 8'h45) mdl <= 8'h18;
        if (rq) chk(rd, q.pop_front());
        if (nrst && up == 2'b11) chk_ctl(k, want(mp, pp));
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        r(8'h06, 8'h18);
        repeat (6) begin
            v = rng[15:8];
            h.x(1'b1, 8'h06, v);
            r(8'h06, v & 8'h3f);
        end
        h.x(1'b1, 8'h07, 8'hff);
        r(8'h06, v & 8'h3f);
        h.x(1'b1, 8'h09, 8'h44);
        r(8'h06, v & 8'h3f);
        h.x(1'b1, 8'h09, 8'h45);
        r(8'h06, 8'h18);
        r(8'h09, 8'h00);
        h.x(1'b1, 8'h06, 8'h3f);
        // Mid-run reset must bring the power-on byte back
        @(negedge clk) nrst = 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        r(8'h06, 8'h18);
        repeat (4) @(posedge clk);
        wrap_up();
    end
    // About fifty-five cycles are needed; the margin is about ninetyfold
    initial begin
        #20000 mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire

// *** test/regulator_mode_sva.sv ***
/*
 * Concurrent checks on the mode outputs and read data of the register block.
 * Assumes it sees only the block's ports and shares its single clock.
 */
`default_nettype none
module regulator_mode_sva import regulator_mode_pkg::*; (
    input wire logic         mclk_i,
    input wire logic         nrst_i,
    input wire reg_access_t  access_i,
    input wire logic         enable_pin_i,
    input wire logic         voltage_select_pin_i,
    input wire logic         startup_i,
    input wire logic [7:0]   rdata_o,
    input wire control_out_t ctl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // Byte written, then a quiet cycle while it reaches the controls
    sequence w6;
        nrst_i && access_i.wr && access_i.addr == 8'h06 ##1 !access_i.wr;
    endsequence
    sequence key_write;
        nrst_i && access_i.wr && access_i.addr == 8'h09 && access_i.wdata == 8'h45
            ##1 !access_i.wr;
    endsequence
    AST_TONE: assert property (w6 |=> ctl_o.tone_reduction == $past(access_i.wdata[5], 2))
        else $error("tone level differs from written bit");
    AST_FCC: assert property (w6 |=> ctl_o.forced_continuous_operation ==
        ($past(access_i.wdata[1], 2) || ($past(access_i.wdata[2], 2) && $past(voltage_select_pin_i))))
        else $error("continuous level differs from written bits");
    AST_RAMP: assert property (ctl_o.forced_continuous_operation |-> ctl_o.ramp_active)
        else $error("ramp off under forced continuous");
    AST_START: assert property (nrst_i && startup_i |=> ctl_o.ramp_active)
        else $error("ramp off during start-up");
    AST_DIS: assert property (ctl_o.converter_run |-> !ctl_o.discharge_connect)
        else $error("discharge while running");
    AST_RUN: assert property (nrst_i && !enable_pin_i |=> !ctl_o.converter_run)
        else $error("running with enable pin low");
    AST_SEL: assert property (nrst_i |=> ctl_o.second_target_voltage == $past(voltage_select_pin_i))
        else $error("target select differs from pin");
    AST_KEY: assert property (key_write |=> !ctl_o.tone_reduction && ctl_o.ramp_active)
        else $error("key did not restore defaults");
    AST_RAMP_FOLLOW: assert property (w6 |=> ctl_o.ramp_active == ($past(access_i.wdata[4], 2)
        || $past(startup_i) || ctl_o.forced_continuous_operation))
        else $error("ramp level differs from written bit");
    AST_RUN_FOLLOW: assert property (w6 |=> ctl_o.converter_run ==
        ($past(access_i.wdata[0], 2) && $past(enable_pin_i)))
        else $error("run level differs from bit and pin");
    AST_DISCHARGE: assert property (w6 |=> ctl_o.discharge_connect ==
        ($past(access_i.wdata[3], 2) && !ctl_o.converter_run))
        else $error("discharge level differs from written bit");
    AST_KEY_READ: assert property (nrst_i && access_i.rd && access_i.addr == 8'h09
        |=> rdata_o == 8'h00)
        else $error("restore register read not zero");
endmodule
bind regulator_mode_enable_regs regulator_mode_sva chk (
    .mclk_i               (mclk_i),
    .nrst_i               (nrst_i),
    .access_i             (access_i),
    .enable_pin_i         (enable_pin_i),
    .voltage_select_pin_i (voltage_select_pin_i),
    .startup_i            (startup_i),
    .rdata_o              (rdata_o),
    .ctl_o                (ctl_o)
);
`default_nettype wire

// *** verilog/regulator_mode_enable_regs.sv ***
/*
 * Mode and enable control register plus key-guarded default restore register.
 * Assumes bus accesses and pins are synchronous to mclk_i; analog loop is outside.
 */
`default_nettype none
// How it works
// - bit 5 enables audible tone reduction
// - bit 4 allows steady-state output ramping
// - start-up always ramps regardless of bit 4
// - forced continuous conduction keeps ramping active
// - bit 3 connects discharge only in shutdown
// - bit 2 lets high select pin force continuous
// - bit 1 forces continuous conduction always
// - converter runs when bit 0 and pin high
// - key 45h restores all defaults
// - select pin high picks second target
module regulator_mode_enable_regs (
    input  wire logic                              mclk_i,
    input  wire logic                              nrst_i,
    input  wire regulator_mode_pkg::reg_access_t   access_i,
    input  wire logic                              enable_pin_i,
    input  wire logic                              voltage_select_pin_i,
    input  wire logic                              startup_i,
    output logic [7:0]                             rdata_o,
    output regulator_mode_pkg::control_out_t       ctl_o
);
    import regulator_mode_pkg::*;

    // Whole state in one struct; only the enable byte is bus-programmable
    state_t state_reg;
    state_t state_next;

    // Write strobe aimed at one offset
    function automatic logic write_hits(
        input reg_access_t acc,
        input logic [7:0]  offset
    );
        logic hit;
        hit = 1'b0;
        if (acc.wr && (acc.addr == offset)) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Read strobe aimed at one offset
    function automatic logic read_hits(
        input reg_access_t acc,
        input logic [7:0]  offset
    );
        logic hit;
        hit = 1'b0;
        if (acc.rd && (acc.addr == offset)) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Exact key only, so a stray write to the restore offset is harmless
    function automatic logic restore_requested(
        input reg_access_t acc
    );
        logic hit;
        hit = 1'b0;
        if (write_hits(acc, SOFTWARE_DEFAULT_RESTORE_OFFSET) && (acc.wdata == RESTORE_KEY)) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Upper two bits are unused and always store zero
    function automatic logic [7:0] stored_byte(
        input logic [7:0] wdata
    );
        logic [7:0] kept;
        kept = wdata & WRITABLE_MASK;
        return kept;
    endfunction

    // Next enable byte; the key brings back the power-on value of every field
    function automatic logic [7:0] next_enable(
        input logic [7:0]  current,
        input reg_access_t acc
    );
        logic [7:0] value;
        value = current;
        if (write_hits(acc, CONVERTER_MODE_ENABLE_OFFSET)) begin
            value = stored_byte(acc.wdata);
        end
        if (restore_requested(acc)) begin
            value = CONVERTER_MODE_ENABLE_RESET;
        end
        return value;
    endfunction

    // Restore register is write-only and reads zero, as do unmapped offsets
    function automatic logic [7:0] read_value(
        input logic [7:0]  current,
        input reg_access_t acc
    );
        logic [7:0] value;
        value = 8'h00;
        if (read_hits(acc, CONVERTER_MODE_ENABLE_OFFSET)) begin
            value = current;
        end
        return value;
    endfunction

    // Locked by bit 1, or by a high select pin when bit 2 allows it
    function automatic logic continuous_forced(
        input logic [7:0] bits,
        input logic       select_pin
    );
        logic forced;
        forced = 1'b0;
        if (bits[CONTINUOUS_LOCK_BIT]) begin
            forced = 1'b1;
        end
        if (bits[SELECT_PIN_FORCES_BIT] && select_pin) begin
            forced = 1'b1;
        end
        return forced;
    endfunction

    // Ramping cannot be turned off during start-up or forced continuous conduction
    function automatic logic ramp_needed(
        input logic [7:0] bits,
        input logic       starting,
        input logic       forced
    );
        logic ramp;
        ramp = 1'b0;
        if (bits[RAMP_ALLOW_BIT]) begin
            ramp = 1'b1;
        end
        if (starting) begin
            ramp = 1'b1;
        end
        if (forced) begin
            ramp = 1'b1;
        end
        return ramp;
    endfunction

    // Stored bit and pin must both be high; neither alone starts the converter
    function automatic logic run_allowed(
        input logic [7:0] bits,
        input logic       pin
    );
        logic run;
        run = 1'b0;
        if (bits[CONVERTER_ENABLE_BIT] && pin) begin
            run = 1'b1;
        end
        return run;
    endfunction

    // Shutdown is taken as any cycle in which the converter is not running
    function automatic logic discharge_wanted(
        input logic [7:0] bits,
        input logic       running
    );
        logic connect;
        connect = 1'b0;
        if (bits[DISCHARGE_BIT] && !running) begin
            connect = 1'b1;
        end
        return connect;
    endfunction

    // Levels from the stored byte and the pins as they stand this cycle
    function automatic control_out_t control_levels(
        input logic [7:0] bits,
        input logic       select_pin,
        input logic       enable_pin,
        input logic       starting
    );
        control_out_t ctl;
        logic         fcc;
        logic         run;
        fcc = continuous_forced(bits, select_pin);
        run = run_allowed(bits, enable_pin);
        ctl.tone_reduction              = bits[TONE_REDUCTION_BIT];
        ctl.forced_continuous_operation = fcc;
        ctl.ramp_active                 = ramp_needed(bits, starting, fcc);
        ctl.converter_run               = run;
        ctl.discharge_connect           = discharge_wanted(bits, run);
        ctl.second_target_voltage       = select_pin;
        return ctl;
    endfunction

    always_comb begin
        state_next            = state_reg;
        state_next.enable_reg = next_enable(state_reg.enable_reg, access_i);

        // Read data holds until the next read; a same-cycle write shows on the next one
        if (access_i.rd) begin
            state_next.rdata = read_value(state_reg.enable_reg, access_i);
        end

        // Controls trail a write by one cycle since they use the stored byte
        state_next.ctl = control_levels(state_reg.enable_reg, voltage_select_pin_i,
                                        enable_pin_i, startup_i);
    end

    // Reset loads constants only; the key reuses the same power-on value
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg.enable_reg                      <= CONVERTER_MODE_ENABLE_RESET;
            state_reg.rdata                           <= 8'h00;
            state_reg.ctl.tone_reduction              <= 1'b0;
            state_reg.ctl.ramp_active                 <= 1'b0;
            state_reg.ctl.discharge_connect           <= 1'b0;
            state_reg.ctl.forced_continuous_operation <= 1'b0;
            state_reg.ctl.converter_run               <= 1'b0;
            state_reg.ctl.second_target_voltage       <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs are register bits, so no pin sees a combinational glitch
    assign rdata_o = state_reg.rdata;
    assign ctl_o   = state_reg.ctl;
endmodule
`default_nettype wire

// *** verilog/regulator_mode_pkg.sv ***
/*
 * Constants and carrier types for the regulator mode and enable registers.
 * Assumes a bus protocol engine outside that delivers decoded byte accesses.
 */
`default_nettype none
package regulator_mode_pkg;
    localparam logic [7:0] CONVERTER_MODE_ENABLE_OFFSET    = 8'h06;
    localparam logic [7:0] SOFTWARE_DEFAULT_RESTORE_OFFSET = 8'h09;
    localparam logic [7:0] CONVERTER_MODE_ENABLE_RESET     = 8'h18;
    localparam logic [7:0] RESTORE_KEY                     = 8'h45;
    localparam int         TONE_REDUCTION_BIT              = 5;
    localparam int         RAMP_ALLOW_BIT                  = 4;
    localparam int         DISCHARGE_BIT                   = 3;
    localparam int         SELECT_PIN_FORCES_BIT           = 2;
    localparam int         CONTINUOUS_LOCK_BIT             = 1;
    localparam int         CONVERTER_ENABLE_BIT            = 0;
    localparam logic [7:0] WRITABLE_MASK                   = 8'h3f;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_t;

    typedef struct packed {
        logic tone_reduction;
        logic ramp_active;
        logic discharge_connect;
        logic forced_continuous_operation;
        logic converter_run;
        logic second_target_voltage;
    } control_out_t;

    typedef struct packed {
        logic [7:0]   enable_reg;
        logic [7:0]   rdata;
        control_out_t ctl;
    } state_t;
endpackage
`default_nettype wire
